// >>> hdl/csi_pkg.sv
package csi_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_STACK_POINTER = 8'h00;
    localparam logic [7:0] ADDR_STACK_TOP_LOW = 8'h04;
    localparam logic [7:0] ADDR_STACK_TOP_HIGH = 8'h08;
    localparam logic [7:0] ADDR_CONTROL = 8'h0C;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_PTR0 = 8'h14;
    localparam logic [7:0] ADDR_PTR1 = 8'h18;
    // ---------------------------------------------------------------
    // sizes and reset values
    // ---------------------------------------------------------------
    localparam int STACK_DEPTH = 16;
    localparam int PC_W = 15;
    localparam int SP_W = 5;
    localparam logic [4:0] SP_RESET = 5'h1F;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    // ---------------------------------------------------------------
    // indirect address map
    // ---------------------------------------------------------------
    localparam logic [15:0] TRAD_LAST = 16'h0FFF;
    localparam logic [15:0] LIN_BASE = 16'h2000;
    localparam logic [15:0] LIN_LAST = 16'h29AF;
    localparam int LIN_BLOCK = 80;
    localparam logic [6:0] LIN_BANK_OFS = 7'h20;
    localparam logic [11:0] PORT0_ADDR = 12'h000;
    localparam logic [11:0] PORT1_ADDR = 12'h001;
    localparam int FLASH_BIT = 15;
    localparam int FLASH_EXTRA_CYCLES = 1;
    // ---------------------------------------------------------------
    // power control bits and access state
    // ---------------------------------------------------------------
    localparam int POWER_CONTROL_REG_OVF_BIT = 7;
    localparam int POWER_CONTROL_REG_UNF_BIT = 6;
    typedef enum logic [1:0] {
        IA_IDLE = 2'b00,
        IA_FLASH = 2'b01,
        IA_DONE = 2'b10
    } csi_ia_state_t;
endpackage

// >>> hdl/csi_stack_if.sv
`timescale 1ns/1ns
`default_nettype none
interface csi_stack_if;
    logic we;
    logic [3:0] waddr;
    logic [14:0] wdata;
    logic [3:0] raddr;
    logic [14:0] rdata;
    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> hdl/csi_stack_mem.sv
`timescale 1ns/1ns
`default_nettype none
module csi_stack_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 15
) (
    input wire logic core_clk_i,
    csi_stack_if.mem bus
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    // ---------------------------------------------------------------
    // storage, registered read
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (bus.we) begin
            mem_reg[bus.waddr] <= bus.wdata;
        end
        bus.rdata <= (bus.we && bus.waddr == bus.raddr) ? bus.wdata : mem_reg[bus.raddr];
    end
endmodule
`default_nettype wire

// >>> hdl/csi_core.sv
`timescale 1ns/1ns
`default_nettype none
module csi_core
    import csi_pkg::*;
#(
    parameter int DEPTH = csi_pkg::STACK_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [5:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [5:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [14:0] pc_i,
    output logic [14:0] return_pc_o,
    output logic stack_fault_reset_o,
    input wire logic ia_req_i,
    input wire logic ia_sel_i,
    input wire logic ia_write_i,
    input wire logic [7:0] ia_wdata_i,
    output logic ia_done_o,
    output logic [7:0] ia_rdata_o,
    output logic data_we_o,
    output logic data_re_o,
    output logic [11:0] data_addr_o,
    output logic [7:0] data_wdata_o,
    input wire logic [7:0] data_rdata_i,
    input wire logic data_hit_i,
    output logic flash_re_o,
    output logic [14:0] flash_addr_o,
    input wire logic [13:0] flash_rdata_i
);
    import csi_pkg::*;
    csi_stack_if stk ();
    logic [4:0] stack_pointer_reg;
    logic stack_fault_reset_enable;
    logic [7:0] power_control_reg;
    logic [15:0] ptr0_reg;
    logic [15:0] ptr1_reg;
    logic aw_held_reg, w_held_reg;
    logic [5:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire, rd_pend_reg;
    logic [5:0] araddr_reg;
    logic sp_empty, push_ovf, pop_unf;
    logic [14:0] stack_top;
    logic [14:0] top_wr_value;
    logic top_wr;
    csi_ia_state_t ia_state_reg;
    logic [15:0] ia_ptr;
    logic [11:0] lin_mapped;
    logic [15:0] lin_off;
    logic [6:0] lin_bank;
    logic [6:0] lin_mod;
    logic ia_is_flash, ia_is_trad, ia_is_lin, ia_is_port, ia_valid;
    logic [11:0] ia_data_addr;
    logic ia_flash_reg, ia_rd_ok_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
    // ---------------------------------------------------------------
    // stack memory
    // ---------------------------------------------------------------
    csi_stack_mem #(.DEPTH(DEPTH), .WIDTH(PC_W)) u_mem (
        .core_clk_i(core_clk_i),
        .bus(stk)
    );
    assign sp_empty = stack_pointer_reg == SP_RESET;
    assign push_ovf = push_i && stack_pointer_reg == 5'(DEPTH - 1);
    assign pop_unf = pop_i && !push_i && (stack_pointer_reg == 5'h00 || sp_empty);
    assign stack_top = (stack_fault_reset_enable && sp_empty) ? 15'h0000 : stk.rdata;
    assign top_wr = wr_fire && (awaddr_reg == ADDR_STACK_TOP_LOW[5:0] || awaddr_reg == ADDR_STACK_TOP_HIGH[5:0]);
    always_comb begin
        top_wr_value = stk.rdata;
        if (awaddr_reg == ADDR_STACK_TOP_LOW[5:0] && wstrb_reg[0]) begin
            top_wr_value[7:0] = wdata_reg[7:0];
        end
        if (awaddr_reg == ADDR_STACK_TOP_HIGH[5:0] && wstrb_reg[0]) begin
            top_wr_value[14:8] = wdata_reg[6:0];
        end
    end
    // write port: push stores pc at incremented pointer, software writes at pointer
    always_comb begin
        stk.we = 1'b0;
        stk.waddr = stack_pointer_reg[3:0];
        stk.wdata = top_wr_value;
        if (push_i) begin
            stk.we = 1'b1;
            stk.waddr = 4'(stack_pointer_reg + 5'h01);
            stk.wdata = pc_i;
        end else if (top_wr && !sp_empty) begin
            stk.we = 1'b1;
        end
    end
    // read address follows next pointer so top-of-stack is ready one edge later
    always_comb begin
        stk.raddr = stack_pointer_reg[3:0];
        if (push_i) begin
            stk.raddr = 4'(stack_pointer_reg + 5'h01);
        end else if (pop_i) begin
            stk.raddr = 4'(stack_pointer_reg - 5'h01);
        end else if (wr_fire && awaddr_reg == ADDR_STACK_POINTER[5:0] && wstrb_reg[0]) begin
            stk.raddr = wdata_reg[3:0];
        end
    end
    // ---------------------------------------------------------------
    // stack pointer
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stack_pointer_reg <= SP_RESET;
        end else if (stack_fault_reset_enable && (push_ovf || pop_unf)) begin
            stack_pointer_reg <= SP_RESET;
        end else if (push_i) begin
            stack_pointer_reg <= push_ovf ? 5'h00 : 5'(stack_pointer_reg + 5'h01);
        end else if (pop_i) begin
            stack_pointer_reg <= (stack_pointer_reg == 5'h00) ? SP_RESET : 5'(stack_pointer_reg - 5'h01);
        end else if (wr_fire && awaddr_reg == ADDR_STACK_POINTER[5:0] && wstrb_reg[0]) begin
            stack_pointer_reg <= wdata_reg[SP_W-1:0];
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            return_pc_o <= 15'h0000;
        end else if (pop_i && !push_i) begin
            return_pc_o <= stack_top;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stack_fault_reset_o <= 1'b0;
        end else begin
            stack_fault_reset_o <= stack_fault_reset_enable && (push_ovf || pop_unf);
        end
    end
    // ---------------------------------------------------------------
    // control and power control
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stack_fault_reset_enable <= 1'b0;
        end else if (wr_fire && awaddr_reg == ADDR_CONTROL[5:0] && wstrb_reg[0]) begin
            stack_fault_reset_enable <= wdata_reg[0];
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_control_reg <= 8'h00;
        end else begin
            if (wr_fire && awaddr_reg == ADDR_POWER_CONTROL[5:0] && wstrb_reg[0]) begin
                power_control_reg <= power_control_reg & wdata_reg[7:0];
            end
            if (push_ovf) begin
                power_control_reg[POWER_CONTROL_REG_OVF_BIT] <= 1'b1;
            end
            if (pop_unf) begin
                power_control_reg[POWER_CONTROL_REG_UNF_BIT] <= 1'b1;
            end
        end
    end
    // ---------------------------------------------------------------
    // file-select pointers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr0_reg <= PTR_RESET;
            ptr1_reg <= PTR_RESET;
        end else if (wr_fire) begin
            if (awaddr_reg == ADDR_PTR0[5:0]) begin
                if (wstrb_reg[0]) ptr0_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) ptr0_reg[15:8] <= wdata_reg[15:8];
            end
            if (awaddr_reg == ADDR_PTR1[5:0]) begin
                if (wstrb_reg[0]) ptr1_reg[7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) ptr1_reg[15:8] <= wdata_reg[15:8];
            end
        end
    end
    // ---------------------------------------------------------------
    // indirect address decode
    // ---------------------------------------------------------------
    assign ia_ptr = ia_sel_i ? ptr1_reg : ptr0_reg;
    assign lin_off = 16'(ia_ptr - LIN_BASE);
    assign lin_bank = 7'(lin_off / 16'(LIN_BLOCK));
    assign lin_mod = 7'(lin_off % 16'(LIN_BLOCK));
    assign lin_mapped = {lin_bank[4:0], 7'(LIN_BANK_OFS + lin_mod)};
    assign ia_is_flash = ia_ptr[FLASH_BIT];
    assign ia_is_trad = !ia_is_flash && ia_ptr <= TRAD_LAST;
    assign ia_is_lin = !ia_is_flash && ia_ptr >= LIN_BASE && ia_ptr <= LIN_LAST;
    assign ia_data_addr = ia_is_lin ? lin_mapped : ia_ptr[11:0];
    assign ia_is_port = ia_is_trad && (ia_ptr[6:0] == PORT0_ADDR[6:0] || ia_ptr[6:0] == PORT1_ADDR[6:0]);
    assign ia_valid = (ia_is_trad || ia_is_lin) && !ia_is_port;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ia_state_reg <= IA_IDLE;
            ia_flash_reg <= 1'b0;
            ia_rd_ok_reg <= 1'b0;
            ia_done_o <= 1'b0;
            ia_rdata_o <= 8'h00;
            data_we_o <= 1'b0;
            data_re_o <= 1'b0;
            data_addr_o <= 12'h000;
            data_wdata_o <= 8'h00;
            flash_re_o <= 1'b0;
            flash_addr_o <= 15'h0000;
        end else begin
            ia_done_o <= 1'b0;
            data_we_o <= 1'b0;
            data_re_o <= 1'b0;
            flash_re_o <= 1'b0;
            case (ia_state_reg)
                IA_IDLE: begin
                    if (ia_req_i && ia_is_flash) begin
                        flash_re_o <= !ia_write_i;
                        ia_flash_reg <= 1'b1;
                        ia_rd_ok_reg <= !ia_write_i;
                        flash_addr_o <= ia_ptr[14:0];
                        ia_state_reg <= IA_FLASH;
                    end else if (ia_req_i) begin
                        data_addr_o <= ia_data_addr;
                        data_we_o <= ia_write_i && ia_valid;
                        data_re_o <= !ia_write_i && ia_valid;
                        data_wdata_o <= ia_wdata_i;
                        ia_flash_reg <= 1'b0;
                        ia_rd_ok_reg <= !ia_write_i && ia_valid;
                        ia_state_reg <= IA_DONE;
                    end
                end
                IA_FLASH: begin
                    ia_state_reg <= IA_DONE;
                end
                IA_DONE: begin
                    ia_done_o <= 1'b1;
                    if (ia_flash_reg) begin
                        ia_rdata_o <= ia_rd_ok_reg ? flash_rdata_i[7:0] : 8'h00;
                    end else begin
                        ia_rdata_o <= (ia_rd_ok_reg && data_hit_i) ? data_rdata_i : 8'h00;
                    end
                    ia_state_reg <= IA_IDLE;
                end
                default: begin
                    ia_state_reg <= IA_IDLE;
                end
            endcase
        end
    end
    // ---------------------------------------------------------------
    // axi4-lite write channel
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 6'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= 2'b00;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= {s_axi_awaddr_i[5:2], 2'b00};
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata_i;
                wstrb_reg <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (awaddr_reg > ADDR_PTR1[5:0]) ? 2'b10 : 2'b00;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end
    // ---------------------------------------------------------------
    // axi4-lite read channel
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_pend_reg <= 1'b0;
            araddr_reg <= 6'h00;
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= 2'b00;
        end else begin
            rd_pend_reg <= 1'b0;
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                araddr_reg <= {s_axi_araddr_i[5:2], 2'b00};
                rd_pend_reg <= 1'b1;
                s_axi_arready_o <= 1'b0;
            end
            if (rd_pend_reg) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= 2'b00;
                case (araddr_reg)
                    ADDR_STACK_POINTER[5:0]: s_axi_rdata_o <= {27'h0, stack_pointer_reg};
                    ADDR_STACK_TOP_LOW[5:0]: s_axi_rdata_o <= {24'h0, stack_top[7:0]};
                    ADDR_STACK_TOP_HIGH[5:0]: s_axi_rdata_o <= {25'h0, stack_top[14:8]};
                    ADDR_CONTROL[5:0]: s_axi_rdata_o <= {31'h0, stack_fault_reset_enable};
                    ADDR_POWER_CONTROL[5:0]: s_axi_rdata_o <= {24'h0, power_control_reg};
                    ADDR_PTR0[5:0]: s_axi_rdata_o <= {16'h0, ptr0_reg};
                    ADDR_PTR1[5:0]: s_axi_rdata_o <= {16'h0, ptr1_reg};
                    default: begin
                        s_axi_rdata_o <= 32'h00000000;
                        s_axi_rresp_o <= 2'b10;
                    end
                endcase
            end
            if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
                s_axi_arready_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/csi_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module csi_core_asserts (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [14:0] pc_i,
    input wire logic [14:0] return_pc_o,
    input wire logic stack_fault_reset_o,
    input wire logic ia_done_o,
    input wire logic [7:0] ia_rdata_o,
    input wire logic data_we_o,
    input wire logic data_re_o,
    input wire logic [7:0] data_rdata_i,
    input wire logic data_hit_i,
    input wire logic flash_re_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence push_then_pop;
        push_i && !pop_i ##1 pop_i && !push_i && !stack_fault_reset_o;
    endsequence
    sequence data_read;
        data_re_o ##1 ia_done_o;
    endsequence
    a_push_pop_return: assert property (push_then_pop |=> return_pc_o == $past(pc_i, 2))
        else $error("popped value differs from pushed pc");
    a_fault_one_pulse: assert property (stack_fault_reset_o |-> $past(push_i || pop_i) ##1 !stack_fault_reset_o)
        else $error("fault reset pulse without cause or too long");
    a_data_done_next: assert property ((data_re_o || data_we_o) |=> ia_done_o)
        else $error("data access not completed next cycle");
    a_data_read_value: assert property (data_read |->
        ia_rdata_o == ($past(data_hit_i) ? $past(data_rdata_i) : 8'h00))
        else $error("indirect read data wrong");
    a_flash_extra_cycle: assert property (flash_re_o |=> !ia_done_o ##1 ia_done_o)
        else $error("flash access not one cycle longer");
    a_flash_no_write: assert property (flash_re_o |=> !data_we_o [*2])
        else $error("data write during flash access");
    a_strobe_exclusive: assert property ($onehot0({data_we_o, data_re_o, flash_re_o}))
        else $error("several memory strobes at once");
    a_read_latency: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##2 s_axi_rvalid_o)
        else $error("register read answer late");
endmodule
bind csi_core csi_core_asserts u_chk (.*);
`default_nettype wire

// >>> testbench/cpu_stack_and_indirect_addressing_bench.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_stack_and_indirect_addressing_bench;
    import csi_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] s_axi_awaddr_i = 6'h00;
    logic [5:0] s_axi_araddr_i = 6'h00;
    logic s_axi_awvalid_i = 1'b0;
    logic s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'h0;
    logic push_i = 1'b0;
    logic pop_i = 1'b0;
    logic [14:0] pc_i = 15'h0;
    logic ia_req_i = 1'b0;
    logic ia_sel_i = 1'b0;
    logic ia_write_i = 1'b0;
    logic [7:0] ia_wdata_i = 8'h00;
    logic data_hit_i = 1'b1;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
    logic [31:0] s_axi_rdata_o, rd;
    logic [14:0] return_pc_o, flash_addr_o, seen_addr;
    logic [7:0] ia_rdata_o, data_wdata_o, data_rdata_i, seen_data;
    logic stack_fault_reset_o, ia_done_o, data_we_o, data_re_o, flash_re_o;
    logic [11:0] data_addr_o;
    logic [13:0] flash_rdata_i;
    logic [15:0] p;
    logic [15:0] cases [8] = '{16'h0123, 16'h0000, 16'h0081, 16'h2000, 16'h29AF, 16'h1000, 16'h8000, 16'hFFFF};
    logic [14:0] stk [16];
    int errors = 0, tests_run = 0, sp = 31, en = 0, faults = 0, writes = 0, pend = -1;

    csi_core dut (.*);
    // ----
    // memory models
    // ----
    assign data_rdata_i = data_addr_o[7:0] ^ 8'h3C;
    assign flash_rdata_i = {flash_addr_o[5:0], ~flash_addr_o[7:0]};
    always #25 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        if (stack_fault_reset_o === 1'b1) faults++;
        if (data_we_o === 1'b1) writes++;
        if ((data_we_o | data_re_o | flash_re_o) === 1'b1) begin
            seen_addr = flash_re_o ? flash_addr_o : {3'h0, data_addr_o};
            seen_data = data_wdata_o;
        end
    end
    always @(negedge core_clk_i) begin
        if (pend >= 0) chk(32'(return_pc_o), pend);
        pend = -1;
    end
    // ----
    // tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        @(posedge core_clk_i);
        s_axi_awaddr_i <= a[5:0];
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= s;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b0;
        rsp = s_axi_bresp_o;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge core_clk_i);
        s_axi_araddr_i <= a[5:0];
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b0;
        rd = s_axi_rdata_o;
        rsp = s_axi_rresp_o;
    endtask
    task automatic stk_op(input bit push, input logic [14:0] pc);
        push_i <= push;
        pop_i <= !push;
        pc_i <= pc;
        @(posedge core_clk_i);
        if (push && sp == 15) sp = en ? 31 : 0;
        else if (push) sp = (sp + 1) % 32;
        if (push && sp != 31) stk[sp] = pc;
        if (!push && (sp == 0 || sp == 31)) sp = en ? 31 : (sp + 31) % 32;
        else if (!push) begin
            pend = stk[sp];
            sp = sp - 1;
        end
    endtask
    task automatic idle;
        push_i <= 1'b0;
        pop_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic ia(input logic [15:0] ptr, input bit wr);
        int kind = 0, lat = 0, w0, n;
        logic [14:0] a = 15'h0;
        logic [7:0] wd = 8'($urandom);
        logic hit = 1'($urandom);
        logic sel = 1'($urandom);
        logic [7:0] ex;
        n = int'(ptr) - int'(LIN_BASE);
        if (ptr[15]) kind = 2;
        else if (ptr <= TRAD_LAST && ptr[6:0] > 7'h01) kind = 1;
        else if (ptr >= LIN_BASE && ptr <= LIN_LAST) kind = 1;
        if (ptr[15]) a = ptr[14:0];
        else if (ptr <= TRAD_LAST) a = {3'h0, ptr[11:0]};
        else a = 15'((n / LIN_BLOCK) * 128 + 32 + n % LIN_BLOCK);
        ex = kind == 2 ? ~a[7:0] : ((kind == 1 && hit) ? a[7:0] ^ 8'h3C : 8'h00);
        axi_wr(sel ? ADDR_PTR1 : ADDR_PTR0, {16'h0000, ptr}, 4'h3);
        w0 = writes;
        ia_req_i <= 1'b1;
        ia_sel_i <= sel;
        ia_write_i <= wr;
        ia_wdata_i <= wd;
        data_hit_i <= hit;
        do begin
            @(posedge core_clk_i);
            ia_req_i <= 1'b0;
            lat++;
        end while (ia_done_o !== 1'b1 && lat < 20);
        if (!wr) chk(32'(ia_rdata_o), 32'(ex));
        if (kind != 0 && !(wr && kind == 2)) chk(32'(seen_addr), 32'(a));
        if (kind != 0 && !(wr && kind == 2)) chk(lat, kind == 2 ? 4 : 3);
        chk(writes - w0, (wr && kind == 1) ? 1 : 0);
        if (wr && kind == 1) chk(32'(seen_data), 32'(wd));
    endtask
    initial begin
        repeat (20000) @(posedge core_clk_i);
        errors++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'h5BD7));
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        axi_rd(ADDR_STACK_POINTER);
        chk(rd, 32'h1F);
        axi_rd(ADDR_POWER_CONTROL);
        chk(rd, 32'h0);
        axi_rd(8'h1C);
        chk({rd[29:0], rsp}, 32'h2);
        axi_wr(8'h1C, 32'h1);
        chk(32'(rsp), 32'h2);
        axi_wr(ADDR_CONTROL, 32'h1);
        axi_rd(ADDR_STACK_TOP_LOW);
        chk(rd, 32'h0);
        $display("test reset done");
        axi_wr(ADDR_CONTROL, 32'h0);
        en = 0;
        for (int i = 0; i < 20; i++) stk_op(1'b1, 15'($urandom));
        idle();
        axi_rd(ADDR_STACK_POINTER);
        chk(rd, 32'(sp));
        axi_wr(ADDR_STACK_POINTER, 32'h0);
        axi_rd(ADDR_STACK_TOP_HIGH);
        chk(rd, 32'(stk[0][14:8]));
        axi_wr(ADDR_STACK_POINTER, 32'h3);
        axi_wr(ADDR_STACK_TOP_LOW, 32'hA5);
        axi_wr(ADDR_STACK_TOP_HIGH, 32'h5A);
        stk[3] = 15'h5AA5;
        axi_rd(ADDR_POWER_CONTROL);
        chk(rd, 32'h80);
        axi_wr(ADDR_POWER_CONTROL, 32'h0);
        stk_op(1'b1, 15'h1234);
        for (int i = 0; i < 5; i++) stk_op(1'b0, 15'h0);
        idle();
        axi_rd(ADDR_POWER_CONTROL);
        chk(rd, 32'h40);
        axi_rd(ADDR_STACK_POINTER);
        chk(rd, 32'(sp));
        axi_wr(ADDR_POWER_CONTROL, 32'h0);
        $display("test circular stack done");
        axi_wr(ADDR_CONTROL, 32'h1);
        en = 1;
        for (int i = 0; i < 17; i++) stk_op(1'b1, 15'($urandom));
        idle();
        axi_rd(ADDR_STACK_TOP_HIGH);
        chk(rd, 32'h0);
        chk(faults, 1);
        stk_op(1'b0, 15'h0);
        idle();
        axi_rd(ADDR_POWER_CONTROL);
        chk(rd, 32'hC0);
        chk(faults, 2);
        $display("test fault reset done");
        foreach (cases[i]) begin
            ia(cases[i], 1'b0);
            ia(cases[i], 1'b1);
        end
        for (int i = 0; i < 30; i++) begin
            case (i % 3)
                0: p = {4'h0, 12'($urandom)};
                1: p = LIN_BASE + 16'($urandom_range(0, 32'(LIN_LAST - LIN_BASE)));
                default: p = {1'b1, 15'($urandom)};
            endcase
            ia(p, 1'($urandom));
        end
        $display("test indirect done");
        end_of_test;
    end
endmodule
`default_nettype wire
